/* core/ahb_host_port.sv */
// converter host port: strobes, channel latch, SAR sequencer, byte-wide read bus
// assumes host strobes synchronous to i_ref_clk; comparator decision is an input
`default_nettype none

// Overview of operation
// [R1] drive data bus only when select and read low
// [R2] high byte: status, three zeros, result 11..8
// [R3] low byte: result bits 7..0
// [R4] status flag one while converting
// [R5] busy output low only during conversion
// [R6] select plus write low starts conversion
// [R7] channel address latched when write rises
// [R8] latched address picks channel zero to three
// [R9] host holds write long enough
// [R10] result is twelve bits, msb bit 11
// [R11] conversion takes about 120 microseconds
// [R12] external clock: host keeps write ten microseconds
// [R13] read mid conversion returns partial SAR
// [R14] write during conversion restarts it
// [R15] auto-zero then twelve bit decisions, msb first
// [R16] finished result held until next start
// [R17] reads have no side effect
module ahb_host_port
    import ahb_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // host bus
    input wire ahb_host_t i_host,
    output logic [DB_W-1:0] o_data_bus_pins,
    output logic o_data_bus_oe,
    output logic o_busy_n,
    // analog side
    input wire logic i_comp_above,
    output logic [CH_W-1:0] o_chan_sel,
    output logic o_autozero,
    output logic [RES_W-1:0] o_dac_code
);
    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    ahb_state_t state_r, state_nxt;
    logic [RES_W-1:0] sar_r, sar_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [CH_W-1:0] chan_r, chan_nxt;
    logic wr_prev_r, wr_prev_nxt;
    logic busy_n_r, busy_n_nxt;
    logic az_r, az_nxt;
    logic wr_act, wr_rise;

    assign wr_act = ~i_host.cs_n & ~i_host.wr_n;
    // select may rise together with write, so latch on the end of the pair
    assign wr_rise = ~wr_prev_r & ~wr_act;

    always_comb begin
        state_nxt = state_r;
        sar_nxt = sar_r;
        cnt_nxt = cnt_r;
        bit_nxt = bit_r;
        chan_nxt = chan_r;
        az_nxt = az_r;
        wr_prev_nxt = ~wr_act;
        busy_n_nxt = busy_n_r;
        if (wr_act) begin
            // holding write keeps the converter in auto-zero; restart wins [R6] [R14]
            state_nxt = AHB_AZERO;
            cnt_nxt = '0;
            sar_nxt = RES_RST;
            busy_n_nxt = 1'b0;
            az_nxt = 1'b1;
        end else begin
            if (wr_rise) begin
                chan_nxt = {i_host.chan_addr_high, i_host.chan_addr_low}; // [R7] [R8]
            end
            case (state_r)
                AHB_IDLE: begin
                    busy_n_nxt = 1'b1; // [R5]
                end
                AHB_AZERO: begin
                    if (cnt_r >= CNT_W'(AZ_CYCLES - 1)) begin // [R15]
                        state_nxt = AHB_CONV;
                        cnt_nxt = '0;
                        bit_nxt = 4'(RES_W - 1);
                        sar_nxt = RES_RST | (RES_W'(1) << (RES_W - 1));
                        az_nxt = 1'b0;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
                AHB_CONV: begin
                    if (cnt_r >= CNT_W'(BIT_CYCLES - 1)) begin // [R11]
                        cnt_nxt = '0;
                        // trial bit stays only if input is above the dac code [R15]
                        if (!i_comp_above) begin
                            sar_nxt[bit_r] = 1'b0;
                        end
                        if (bit_r == 4'h0) begin
                            state_nxt = AHB_IDLE;
                            busy_n_nxt = 1'b1; // [R5]
                        end else begin
                            bit_nxt = bit_r - 1'b1;
                            sar_nxt[bit_r - 1'b1] = 1'b1;
                        end
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
                default: state_nxt = AHB_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state_r <= AHB_IDLE;
            sar_r <= RES_RST;
            cnt_r <= '0;
            bit_r <= 4'h0;
            chan_r <= CH_RST;
            az_r <= 1'b0;
            wr_prev_r <= 1'b1;
            busy_n_r <= 1'b1;
        end else if (i_clk_en) begin
            state_r <= state_nxt;
            sar_r <= sar_nxt; // [R16]
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            chan_r <= chan_nxt;
            az_r <= az_nxt;
            wr_prev_r <= wr_prev_nxt;
            busy_n_r <= busy_n_nxt;
        end
    end

    assign o_busy_n = busy_n_r;
    assign o_chan_sel = chan_r;
    assign o_autozero = az_r;
    assign o_dac_code = sar_r;

    // ------------------------------------------------------------
    // read bus
    // ------------------------------------------------------------
    logic [DB_W-1:0] dout_r, dout_nxt;
    logic oe_r, oe_nxt;
    logic rd_act;

    assign rd_act = ~i_host.cs_n & ~i_host.rd_n;

    // read path only looks at state, never changes it [R17]
    always_comb begin
        oe_nxt = rd_act; // [R1]
        dout_nxt = '0;
        if (rd_act) begin
            if (i_host.byte_select_in) begin
                // status is the busy sense inverted: one while converting [R2] [R4]
                dout_nxt[STAT_BIT] = ~busy_n_nxt;
                dout_nxt[HI_NIB_W-1:0] = sar_nxt[RES_W-1:DB_W]; // [R10] [R13]
            end else begin
                dout_nxt = sar_nxt[DB_W-1:0]; // [R3]
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            dout_r <= '0;
            oe_r <= 1'b0;
        end else if (i_clk_en) begin
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign o_data_bus_pins = dout_r;
    assign o_data_bus_oe = oe_r;

    // ------------------------------------------------------------
    // conversion length watch
    // ------------------------------------------------------------
    // cycles since the write pair ended; lets the total length be checked
    // without a long repetition in a property
    logic [CNT_W-1:0] run_cnt_r, run_cnt_nxt;

    always_comb begin
        run_cnt_nxt = run_cnt_r;
        if (wr_act || state_r == AHB_IDLE) begin
            run_cnt_nxt = '0;
        end else if (run_cnt_r != '1) begin
            run_cnt_nxt = run_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            run_cnt_r <= '0;
        end else if (i_clk_en) begin
            run_cnt_r <= run_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // checks: read bus
    // ------------------------------------------------------------
    chk_bus_enable: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R1]
        i_clk_en |=> (o_data_bus_oe == $past(rd_act)))
        else $error("bus enable does not follow select and read");

    chk_bus_quiet: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R1]
        !o_data_bus_oe
        |-> o_data_bus_pins == '0)
        else $error("data bus not quiet outside a read");

    chk_high_zero: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R2]
        $past(i_clk_en) && o_data_bus_oe && $past(i_host.byte_select_in)
        |-> o_data_bus_pins[6:4] == 3'h0)
        else $error("high byte bits 6 to 4 not low");

    chk_high_nibble: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R2]
        $past(i_clk_en) && o_data_bus_oe && $past(i_host.byte_select_in)
        |-> o_data_bus_pins[HI_NIB_W-1:0] == o_dac_code[RES_W-1:DB_W])
        else $error("high byte nibble does not match result");

    chk_low_byte: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R3]
        $past(i_clk_en) && o_data_bus_oe && !$past(i_host.byte_select_in)
        |-> o_data_bus_pins == sar_r[7:0])
        else $error("low byte does not match result");

    chk_status_flag: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R4]
        $past(i_clk_en) && o_data_bus_oe && $past(i_host.byte_select_in)
        |-> o_data_bus_pins[7] == ~o_busy_n)
        else $error("status flag disagrees with busy");

    // ------------------------------------------------------------
    // checks: sequencer
    // ------------------------------------------------------------
    chk_busy_state: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R5]
        o_busy_n == (state_r == AHB_IDLE))
        else $error("busy output disagrees with state");

    chk_az_state: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R15]
        o_autozero == (state_r == AHB_AZERO))
        else $error("auto-zero output disagrees with state");

    chk_write_start: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R14]
        i_clk_en && wr_act |=> state_r == AHB_AZERO && !o_busy_n && cnt_r == '0)
        else $error("write did not restart conversion");

    chk_idle_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R17]
        i_clk_en && !wr_act && state_r == AHB_IDLE
        |=> state_r == AHB_IDLE && o_busy_n)
        else $error("converter left idle without a write");

    chk_chan_latch: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R7]
        i_clk_en && wr_rise |=> o_chan_sel == $past({i_host.chan_addr_high,
            i_host.chan_addr_low}))
        else $error("channel not latched on write rising");

    chk_chan_steady: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R7]
        !(i_clk_en && wr_rise)
        |=> $stable(o_chan_sel))
        else $error("channel changed without a write ending");

    chk_azero_len: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R15]
        $rose(state_r == AHB_CONV) |-> $past(cnt_r) == CNT_W'(AZ_CYCLES - 1))
        else $error("auto-zero interval length wrong");

    chk_azero_bound: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R15]
        state_r == AHB_AZERO |-> cnt_r <= CNT_W'(AZ_CYCLES - 1))
        else $error("auto-zero counter overran");

    chk_msb_trial: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R15]
        $rose(state_r == AHB_CONV)
        |-> o_dac_code == (RES_W'(1) << (RES_W - 1)) && bit_r == 4'(RES_W - 1))
        else $error("conversion did not open with the msb trial");

    chk_bit_period: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R15]
        state_r == AHB_CONV |-> cnt_r <= CNT_W'(BIT_CYCLES - 1))
        else $error("bit period counter overran");

    chk_bit_decide: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R15]
        i_clk_en && !wr_act && state_r == AHB_CONV && cnt_r == CNT_W'(BIT_CYCLES - 1)
        |=> o_dac_code[$past(bit_r)] == $past(i_comp_above))
        else $error("trial bit does not follow the comparator");

    chk_bit_step: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R15]
        i_clk_en && !wr_act && state_r == AHB_CONV && bit_r != 4'h0
        && cnt_r == CNT_W'(BIT_CYCLES - 1)
        |=> bit_r == $past(bit_r) - 4'h1 && o_dac_code[bit_r])
        else $error("next lower trial bit not set");

    chk_done_ready: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R5]
        i_clk_en && !wr_act && state_r == AHB_CONV && bit_r == 4'h0
        && cnt_r == CNT_W'(BIT_CYCLES - 1)
        |=> o_busy_n && state_r == AHB_IDLE)
        else $error("busy not released after the last bit");

    chk_conv_total: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R11]
        $rose(state_r == AHB_IDLE)
        |-> run_cnt_r == CNT_W'(AZ_CYCLES + RES_W * BIT_CYCLES))
        else $error("conversion length differs from the nominal time");

    chk_result_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [R16]
        state_r == AHB_IDLE && $past(state_r == AHB_IDLE) && !$past(wr_act) |-> $stable(sar_r))
        else $error("held result changed while idle");
endmodule
`default_nettype wire

/* inc/ahb_pkg.sv */
// package for the converter host-port block: widths, field positions, timing counts
// assumes a 100 MHz reference clock and synchronous host strobes
`default_nettype none
package ahb_pkg;
    localparam int RES_W = 12;
    localparam int DB_W = 8;
    localparam int CH_W = 2;
    localparam int STAT_BIT = 7;
    localparam int HI_NIB_W = 4;
    localparam int CLK_PERIOD_NS = 10;
    // typical on-chip oscillator conversion time
    localparam int CONV_TIME_US = 120;
    localparam int AUTOZERO_TIME_US = 10;
    localparam int CONV_CYCLES = (CONV_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int AZ_CYCLES = (AUTOZERO_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_CYCLES = (CONV_CYCLES - AZ_CYCLES) / RES_W;
    localparam int CNT_W = 16;
    localparam logic [RES_W-1:0] RES_RST = 12'h000;
    localparam logic [CH_W-1:0] CH_RST = 2'h0;

    typedef enum logic [1:0] {AHB_IDLE, AHB_AZERO, AHB_CONV} ahb_state_t;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic byte_select_in;
        logic chan_addr_high;
        logic chan_addr_low;
    } ahb_host_t;
endpackage
`default_nettype wire

/* testbench/ahb_analog_model.sv */
// analog side model: four fixed channel levels and an ideal comparator
// assumes dac code and channel select come straight from the host port
`default_nettype none
module ahb_analog_model
    import ahb_pkg::*;
(
    // analog side
    input wire logic [CH_W-1:0] i_chan_sel,
    input wire logic [RES_W-1:0] i_dac_code,
    input wire logic [3:0][RES_W-1:0] i_level,
    output logic o_comp_above
);
    timeunit 1ns;
    timeprecision 1ps;
    // keep trial bit while the level is at or above it
    assign o_comp_above = i_level[i_chan_sel] >= i_dac_code;
endmodule
`default_nettype wire

/* testbench/adc_host_bus_interface_tb_top.sv */
// bench for the converter host port, host strobes driven on falling edges
// assumes the analog model answers the comparator input
`default_nettype none
module adc_host_bus_interface_tb_top import ahb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0;
    logic rst = 1;
    logic en = 1;
    ahb_host_t host = 6'h38;
    logic [7:0] db, d;
    logic oe, busy_n, comp, az;
    logic [1:0] chan;
    logic [11:0] dac;
    logic [3:0][11:0] lvl = {12'hf0f, 12'ha5c, 12'h3c7, 12'h123};
    int fails = 0, checks = 0, cyc = 0, n;
    always #5 clk = ~clk;
    ahb_host_port u_ahb_host_port (.i_ref_clk(clk), .i_reset(rst), .i_clk_en(en),
        .i_host(host), .o_data_bus_pins(db), .o_data_bus_oe(oe), .o_busy_n(busy_n),
        .i_comp_above(comp), .o_chan_sel(chan), .o_autozero(az), .o_dac_code(dac));
    ahb_analog_model u_ahb_analog_model (.i_chan_sel(chan), .i_dac_code(dac),
        .i_level(lvl), .o_comp_above(comp));
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic rd(input logic sel, input logic [7:0] exp);
        @(negedge clk);
        host.cs_n = 0;
        host.rd_n = 0;
        host.byte_select_in = sel;
        repeat (2) @(negedge clk);
        check(oe, 1, "bus enable");
        check(db, exp, "read byte");
        host.rd_n = 1;
        host.cs_n = 1;
        repeat (2) @(negedge clk);
        check(oe, 0, "bus release");
    endtask
    // one-cycle write pulse is enough with the on-chip timing
    task automatic start(input logic [1:0] ch);
        @(negedge clk);
        {host.chan_addr_high, host.chan_addr_low} = ch;
        host.cs_n = 0;
        host.wr_n = 0;
        @(negedge clk);
        host.wr_n = 1;
        @(negedge clk);
        host.cs_n = 1;
        {host.chan_addr_high, host.chan_addr_low} = ~ch;
        repeat (2) @(negedge clk);
        check(chan, ch, "channel latch");
        check(busy_n, 0, "busy on start");
        check(az, 1, "auto-zero on start");
    endtask
    task automatic wait_done;
        n = 0;
        while (busy_n !== 1'b1 && n < 13000) begin
            @(negedge clk);
            n++;
        end
        check(n >= 11800 && n <= 12100, 1, "conversion length");
        check(az, 0, "auto-zero after conversion");
    endtask
    task automatic t_reset;
        check({busy_n, oe, db}, 10'h200, "reset outputs");
        $display("test reset done");
    endtask
    task automatic t_convert;
        start(2'h2);
        rd(1, 8'h80);
        check(busy_n, 0, "read side effect");
        wait_done();
        rd(0, 8'h5c);
        rd(1, 8'h0a);
        rd(0, 8'h5c);
        $display("test convert done");
    endtask
    task automatic t_restart;
        start(2'h1);
        repeat (5000) @(negedge clk);
        start(2'h3);
        wait_done();
        rd(1, 8'h0f);
        rd(0, 8'h0f);
        $display("test restart done");
    endtask
    // write held past the auto-zero time, select released together with write
    task automatic t_long_write;
        @(negedge clk);
        {host.chan_addr_high, host.chan_addr_low} = 2'h0;
        host.cs_n = 0;
        host.wr_n = 0;
        repeat (AZ_CYCLES + 10) @(negedge clk);
        check(az, 1, "auto-zero held by write");
        check(busy_n, 0, "busy during long write");
        host.cs_n = 1;
        host.wr_n = 1;
        @(negedge clk);
        {host.chan_addr_high, host.chan_addr_low} = 2'h3;
        @(negedge clk);
        check(chan, 0, "channel latch as select rises");
        repeat (AZ_CYCLES - 50) @(negedge clk);
        check(az, 1, "auto-zero after write");
        repeat (100) @(negedge clk);
        check(az, 0, "auto-zero end");
        rd(1, 8'h88);
        rd(0, 8'h00);
        en = 0;
        repeat (2000) @(negedge clk);
        check({busy_n, dac}, 13'h0800, "frozen by clock enable");
        en = 1;
        start(2'h1);
        wait_done();
        rd(0, 8'hc7);
        rd(1, 8'h03);
        $display("test long write done");
    endtask
    task automatic print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            $display("Error at %0t: timeout", $time);
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        t_reset();
        rst = 0;
        t_convert();
        t_restart();
        t_long_write();
        print_verdict();
    end
endmodule
`default_nettype wire
